// ### design/ivlm_defs.svh
/*
 Constants of the interrupt vector and level map: vector numbers, level
 values, table offsets and the resource-number mask.
 Assumes inclusion by bare name from the package and the modules.
*/
// Contract
// - Each vector word sits at the table base plus an offset that starts at 3fc for vector 0 and falls by 4 per vector.
// - Internal bus diagnosis error, RAM double-bit errors and protection_unit violation raise vector 15 at fixed level 15.
// - CPU exceptions take fixed vectors 5, 6, 7, 8, 9 (debug_trap_instruction), 10 and 14 with no programmable level.
// - Vectors from 16 up take their level from interrupt_level_reg number vector-16; serial ch0 rx/status is 20, tx is 21.
// - Second CAN and all RAM/backup RAM diagnosis requests merge onto vector 35, which has no dma_resource_number.
// - External interrupts 8 to 15 and external low-voltage detection raise vector 17 on level register 1.
// - Zero detection or compare clear of free-running timer 0 raises vector 39 with dma_resource_number 23.
// - output_compare_unit 6/7/10/11 match raises vector 58 (resource 42); units 8/9 raise vector 59 (resource 43).
// - No DMA request is issued for a source that has no dma_resource_number.
// - Serial status and I2C reception requests never start a DMA transfer.
`ifndef IVLM_DEFS_SVH
`define IVLM_DEFS_SVH

`define IVLM_NUM_LVL      48
`define IVLM_TBL_TOP_OFS  10'h3fc
`define IVLM_VEC_LVL_BASE 8'h10
`define IVLM_VEC_NMI      8'h0f
`define IVLM_LVL_NMI      5'h0f
`define IVLM_LVL_NONE     5'h00
`define IVLM_LVL_MASKED   5'h1f
`define IVLM_VEC_FPU      8'h05
`define IVLM_VEC_IPROT    8'h06
`define IVLM_VEC_DPROT    8'h07
`define IVLM_VEC_DACCERR  8'h08
`define IVLM_VEC_DBGTRAP  8'h09
`define IVLM_VEC_IBRK     8'h0a
`define IVLM_VEC_INVALID  8'h0e
`define IVLM_VEC_SW_INT   8'h42
`define IVLM_IDX_EXT_HI   1
`define IVLM_IDX_SIO0_RX  4
`define IVLM_IDX_CAN1_RAM 19
`define IVLM_IDX_FRT0     23
`define IVLM_IDX_CMP_A    42
`define IVLM_IDX_CMP_B    43
`define IVLM_DMA_RES_MASK 48'h3fff_ff83_ffff

`endif

// ### design/ivlm_pkg.sv
/*
 Types shared by the vector map modules.
 Assumes the constants header sits beside it.
*/
`include "ivlm_defs.svh"

package ivlm_pkg;
  typedef logic [7:0] ivlm_vec_t;
  typedef logic [4:0] ivlm_lvl_t;
  typedef enum logic [1:0] {
    IVLM_SRC_NONE,
    IVLM_SRC_EXC,
    IVLM_SRC_NMI,
    IVLM_SRC_LVL
  } ivlm_src_t;
endpackage

// ### design/ivlm_prio_pick.sv
/*
 Picks the pending leveled vector with the smallest level value.
 Assumes pending bits and levels come from logic on the same clock.
*/
`timescale 1ns/1ps
`include "ivlm_defs.svh"

module ivlm_prio_pick
  import ivlm_pkg::*;
#(
  parameter int N  = 48,
  parameter int IW = $clog2(N)
) (
  input  wire logic [N-1:0]   i_pend,
  input  wire logic [N*5-1:0] i_levels,
  output logic                o_any,
  output logic [IW-1:0]       o_idx,
  output ivlm_lvl_t           o_level
);

  // Index must be wide enough to name every pending bit
  if (N < 2 || IW < $clog2(N)) begin : g_bad_param
    $error("ivlm_prio_pick: IW too narrow for N");
  end

  // Strict compare keeps the lower vector on a tie; level 1f never wins
  always_comb begin
    o_any   = 1'b0;
    o_idx   = '0;
    o_level = `IVLM_LVL_MASKED;
    for (int i = 0; i < N; i++) begin
      if (i_pend[i] && (i_levels[i*5 +: 5] < o_level)) begin
        o_any   = 1'b1;
        o_idx   = IW'(i);
        o_level = i_levels[i*5 +: 5];
      end
    end
  end

endmodule

// ### design/ivlm_top.sv
/*
 Interrupt vector and level map: merges source requests onto vectors,
 picks the vector to present, computes its table address and raises DMA
 requests by resource number.
 Assumes every request input is a level from logic on the same clock and
 that the table base and level values are held by the CPU side.
*/
`timescale 1ns/1ps
`include "ivlm_defs.svh"

module ivlm_top
  import ivlm_pkg::*;
#(
  parameter int NUM_LVL = `IVLM_NUM_LVL
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  input  wire logic [31:0]          i_vector_table_base,
  input  wire logic [NUM_LVL*5-1:0] i_interrupt_level_reg,
  input  wire logic [NUM_LVL-1:0]   i_periph_req,
  input  wire logic [3:0]           i_nmi_src,
  input  wire logic [6:0]           i_cpu_exc,
  input  wire logic [7:0]           i_ext_hi_req,
  input  wire logic                 i_ext_lvd_req,
  input  wire logic [6:0]           i_sio_status_req,
  input  wire logic [5:0]           i_ram_diag_req,
  input  wire logic                 i_frt0_zero,
  input  wire logic                 i_frt0_clr,
  input  wire logic [3:0]           i_cmp_a_match,
  input  wire logic [1:0]           i_cmp_b_match,
  output logic                      o_irq_valid,
  output ivlm_vec_t                 o_irq_vector,
  output ivlm_lvl_t                 o_irq_level,
  output logic [31:0]               o_irq_addr,
  output logic                      o_nmi,
  output logic                      o_exception,
  output logic [NUM_LVL-1:0]        o_vec_pending,
  output logic [NUM_LVL-1:0]        o_dma_req
);

  localparam int IW = $clog2(NUM_LVL);

  // Source indices below are fixed to this vector map
  if (NUM_LVL != `IVLM_NUM_LVL) begin : g_bad_num
    $error("ivlm_top: NUM_LVL must be 48");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoding

  function automatic logic [31:0] vec_addr(input logic [31:0] base, input ivlm_vec_t vec);
    logic [9:0] ofs;
    ofs = `IVLM_TBL_TOP_OFS - {vec, 2'b00};
    return base + {22'h0, ofs};
  endfunction

  function automatic ivlm_vec_t exc_vec(input logic [6:0] exc);
    ivlm_vec_t v;
    v = `IVLM_VEC_INVALID;
    for (int i = 6; i >= 0; i--) begin
      if (exc[i]) begin
        case (i)
          0:       v = `IVLM_VEC_FPU;
          1:       v = `IVLM_VEC_IPROT;
          2:       v = `IVLM_VEC_DPROT;
          3:       v = `IVLM_VEC_DACCERR;
          4:       v = `IVLM_VEC_DBGTRAP;
          5:       v = `IVLM_VEC_IBRK;
          default: v = `IVLM_VEC_INVALID;
        endcase
      end
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Merge of shared sources

  logic [NUM_LVL-1:0] pend_comb;
  logic [NUM_LVL-1:0] dma_src;

  always_comb begin
    pend_comb = i_periph_req;
    dma_src   = i_periph_req;
    pend_comb[`IVLM_IDX_EXT_HI]   = i_periph_req[`IVLM_IDX_EXT_HI] | (|i_ext_hi_req) | i_ext_lvd_req;
    dma_src[`IVLM_IDX_EXT_HI]     = i_periph_req[`IVLM_IDX_EXT_HI] | (|i_ext_hi_req);
    pend_comb[`IVLM_IDX_CAN1_RAM] = i_periph_req[`IVLM_IDX_CAN1_RAM] | (|i_ram_diag_req);
    pend_comb[`IVLM_IDX_FRT0]     = i_periph_req[`IVLM_IDX_FRT0] | i_frt0_zero | i_frt0_clr;
    dma_src[`IVLM_IDX_FRT0]       = pend_comb[`IVLM_IDX_FRT0];
    pend_comb[`IVLM_IDX_CMP_A]    = i_periph_req[`IVLM_IDX_CMP_A] | (|i_cmp_a_match);
    dma_src[`IVLM_IDX_CMP_A]      = pend_comb[`IVLM_IDX_CMP_A];
    pend_comb[`IVLM_IDX_CMP_B]    = i_periph_req[`IVLM_IDX_CMP_B] | (|i_cmp_b_match);
    dma_src[`IVLM_IDX_CMP_B]      = pend_comb[`IVLM_IDX_CMP_B];
    // Status shares the rx vector but stays off the DMA path
    for (int k = 0; k < 7; k++) begin
      pend_comb[`IVLM_IDX_SIO0_RX + 2*k] = i_periph_req[`IVLM_IDX_SIO0_RX + 2*k] | i_sio_status_req[k];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Selection

  logic          pick_any;
  logic [IW-1:0] pick_idx;
  ivlm_lvl_t     pick_level;

  ivlm_prio_pick #(
    .N  (NUM_LVL),
    .IW (IW)
  ) u_pick (
    .i_pend   (pend_comb),
    .i_levels (i_interrupt_level_reg),
    .o_any    (pick_any),
    .o_idx    (pick_idx),
    .o_level  (pick_level)
  );

  ivlm_src_t          src_next;
  logic               valid_next;
  logic               valid_reg;
  logic               nmi_next;
  logic               nmi_reg;
  logic               exc_next;
  logic               exc_reg;
  ivlm_vec_t          vec_next;
  ivlm_vec_t          vec_reg;
  ivlm_lvl_t          lvl_next;
  ivlm_lvl_t          lvl_reg;
  logic [31:0]        addr_next;
  logic [31:0]        addr_reg;
  logic [NUM_LVL-1:0] pend_reg;
  logic [NUM_LVL-1:0] dma_next;
  logic [NUM_LVL-1:0] dma_reg;

  // Exceptions first, then the non-maskable vector, then leveled ones
  always_comb begin
    if (|i_cpu_exc) begin
      src_next = IVLM_SRC_EXC;
      vec_next = exc_vec(i_cpu_exc);
      lvl_next = `IVLM_LVL_NONE;
    end else if (|i_nmi_src) begin
      src_next = IVLM_SRC_NMI;
      vec_next = `IVLM_VEC_NMI;
      lvl_next = `IVLM_LVL_NMI;
    end else if (pick_any) begin
      src_next = IVLM_SRC_LVL;
      vec_next = `IVLM_VEC_LVL_BASE + 8'(pick_idx);
      lvl_next = pick_level;
    end else begin
      src_next = IVLM_SRC_NONE;
      vec_next = 8'h00;
      lvl_next = `IVLM_LVL_NONE;
    end
    // Class flags are registered so every output leaves a flip-flop
    valid_next = (src_next != IVLM_SRC_NONE);
    nmi_next   = (src_next == IVLM_SRC_NMI);
    exc_next   = (src_next == IVLM_SRC_EXC);
    addr_next = vec_addr(i_vector_table_base, vec_next);
    dma_next  = dma_src & `IVLM_DMA_RES_MASK;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      valid_reg <= 1'b0;
      nmi_reg   <= 1'b0;
      exc_reg   <= 1'b0;
      vec_reg  <= 8'h00;
      lvl_reg  <= 5'h00;
      addr_reg <= 32'h0000_0000;
      pend_reg <= '0;
      dma_reg  <= '0;
    end else begin
      valid_reg <= valid_next;
      nmi_reg   <= nmi_next;
      exc_reg   <= exc_next;
      vec_reg  <= vec_next;
      lvl_reg  <= lvl_next;
      addr_reg <= addr_next;
      pend_reg <= pend_comb;
      dma_reg  <= dma_next;
    end
  end

  assign o_irq_valid   = valid_reg;
  assign o_nmi         = nmi_reg;
  assign o_exception   = exc_reg;
  assign o_irq_vector  = vec_reg;
  assign o_irq_level   = lvl_reg;
  assign o_irq_addr    = addr_reg;
  assign o_vec_pending = pend_reg;
  assign o_dma_req     = dma_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_addr_offset: assert property (@(posedge i_clk) disable iff (i_rst)
    !$past(i_rst) && o_irq_valid |->
      o_irq_addr == $past(i_vector_table_base) + {22'h0, 10'h3fc - {o_irq_vector, 2'b00}})
    else $error("vector address does not match base and offset");

  a_nmi_fixed: assert property (@(posedge i_clk) disable iff (i_rst)
    !$past(i_rst) && $past(|i_nmi_src) && !$past(|i_cpu_exc) |->
      o_nmi && o_irq_vector == 8'h0f && o_irq_level == 5'h0f)
    else $error("non-maskable vector or level wrong");

  a_exc_invalid: assert property (@(posedge i_clk) disable iff (i_rst)
    !$past(i_rst) && $past(i_cpu_exc) == 7'h40 |-> o_exception && o_irq_vector == 8'h0e)
    else $error("invalid instruction vector wrong");

  a_exc_dbgtrap: assert property (@(posedge i_clk) disable iff (i_rst)
    !$past(i_rst) && $past(i_cpu_exc) == 7'h10 |-> o_irq_vector == 8'h09 && o_irq_level == 5'h00)
    else $error("debug trap vector wrong");

  a_sio0_share: assert property (@(posedge i_clk) disable iff (i_rst)
    !$past(i_rst) && $past(i_sio_status_req[0]) |-> o_vec_pending[4])
    else $error("serial ch0 status not on vector 20");

  a_can_ram_merge: assert property (@(posedge i_clk) disable iff (i_rst)
    !$past(i_rst) && $past(|i_ram_diag_req) |-> o_vec_pending[19] && !o_dma_req[19])
    else $error("RAM diagnosis merge on vector 35 wrong");

  a_lvd_vec17: assert property (@(posedge i_clk) disable iff (i_rst)
    !$past(i_rst) && $past(i_ext_lvd_req) |-> o_vec_pending[1])
    else $error("low-voltage request not on vector 17");

  a_frt0_dma: assert property (@(posedge i_clk) disable iff (i_rst)
    !$past(i_rst) && $past(i_frt0_zero || i_frt0_clr) |-> o_dma_req[23] && o_vec_pending[23])
    else $error("timer 0 request missing on resource 23");

  a_cmp_dma: assert property (@(posedge i_clk) disable iff (i_rst)
    !$past(i_rst) && $past(|i_cmp_b_match) |-> o_dma_req[43] && o_vec_pending[43])
    else $error("compare 8/9 request missing on resource 43");

  a_no_res_dma: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_dma_req & ~48'h3fff_ff83_ffff) == 48'h0)
    else $error("DMA request on vector without resource number");

  a_status_no_dma: assert property (@(posedge i_clk) disable iff (i_rst)
    !$past(i_rst) && $past(i_sio_status_req[0] && !i_periph_req[4]) |-> !o_dma_req[4])
    else $error("serial status started DMA");

  a_merge_release: assert property (@(posedge i_clk) disable iff (i_rst)
    !$past(i_rst) && $past(!i_periph_req[19] && i_ram_diag_req == 6'h00) |-> !o_vec_pending[19])
    else $error("vector 35 pending with no source");

endmodule

// ### verif/ivlm_cpu_model.sv
/*
 CPU-side stand-in: holds the table base and the level registers, and
 records the last hardware vector taken.
 Assumes one clock shared with the vector map.
*/
`timescale 1ns/1ps

module ivlm_cpu_model
  import ivlm_pkg::*;
#(
  parameter logic [31:0] BASE = 32'h000f_fc00
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_irq_valid,
  input  wire ivlm_vec_t  i_irq_vector,
  output logic [31:0]     o_vector_table_base,
  output logic [239:0]    o_interrupt_level_reg,
  output ivlm_vec_t       o_last_vec
);
  // Levels come up masked, so nothing leveled fires before set-up
  logic [239:0] lvl_q = '1;

  assign o_vector_table_base   = BASE;
  assign o_interrupt_level_reg = lvl_q;

  task automatic set_level(input int k, input ivlm_lvl_t v);
    lvl_q[k*5 +: 5] = v;
  endtask

  // Vectors from 40h up belong to software; never taken from hardware
  always_ff @(posedge i_clk or posedge i_rst)
    if (i_rst) o_last_vec <= 8'h00;
    else if (i_irq_valid && i_irq_vector < 8'h40) o_last_vec <= i_irq_vector;
endmodule

// ### verif/testbench.sv
/*
 Self-checking bench for the vector map: one task a scenario.
 Assumes the CPU-side model holds base and levels.
*/
`timescale 1ns/1ps

module testbench;
  import ivlm_pkg::*;
  logic i_clk = 1'b0, i_rst = 1'b1;
  logic [31:0] base;
  logic [239:0] lvls;
  logic [47:0] preq, pend, dma;
  logic [3:0] nmi_src, cmp_a;
  logic [6:0] exc, sio;
  logic [7:0] ext_hi;
  logic [5:0] ram;
  logic lvd, fz, fc, o_irq_valid, o_nmi, o_exception;
  logic [1:0] cmp_b;
  ivlm_vec_t o_irq_vector, last_vec;
  ivlm_lvl_t o_irq_level;
  logic [31:0] o_irq_addr;
  int n_fail = 0, n_compared = 0;

  always #2.5 i_clk = ~i_clk;

  ivlm_top dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_vector_table_base(base),
    .i_interrupt_level_reg(lvls), .i_periph_req(preq), .i_nmi_src(nmi_src),
    .i_cpu_exc(exc), .i_ext_hi_req(ext_hi), .i_ext_lvd_req(lvd),
    .i_sio_status_req(sio), .i_ram_diag_req(ram), .i_frt0_zero(fz),
    .i_frt0_clr(fc), .i_cmp_a_match(cmp_a), .i_cmp_b_match(cmp_b),
    .o_irq_valid(o_irq_valid), .o_irq_vector(o_irq_vector),
    .o_irq_level(o_irq_level), .o_irq_addr(o_irq_addr), .o_nmi(o_nmi),
    .o_exception(o_exception), .o_vec_pending(pend), .o_dma_req(dma));

  ivlm_cpu_model cpu_u (.i_clk(i_clk), .i_rst(i_rst), .i_irq_valid(o_irq_valid),
    .i_irq_vector(o_irq_vector), .o_vector_table_base(base),
    .o_interrupt_level_reg(lvls), .o_last_vec(last_vec));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk_val(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic idle();
    {preq, nmi_src, exc, ext_hi, lvd, sio, ram, fz, fc, cmp_a, cmp_b} = '0;
  endtask

  // Drive just after an edge; results land one edge later
  task automatic step();
    @(posedge i_clk);
    #1;
  endtask

  task automatic chk_irq(input ivlm_vec_t v, input ivlm_lvl_t l, input logic n, input logic e);
    chk_flag(o_irq_valid, 1'b1);
    chk_val(o_irq_vector, v);
    chk_val(o_irq_level, l);
    chk_val(o_irq_addr, base + 32'h0000_03fc - 32'(v) * 4);
    chk_flag(o_nmi, n);
    chk_flag(o_exception, e);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_exc();
    ivlm_vec_t ev[7] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0e};
    for (int i = 0; i < 7; i++) begin
      idle();
      exc = 7'h01 << i;
      nmi_src = 4'h1;
      step();
      chk_irq(ev[i], 5'h00, 1'b0, 1'b1);
    end
  endtask

  task automatic t_nmi();
    for (int i = 0; i < 4; i++) begin
      idle();
      nmi_src = 4'h1 << i;
      step();
      chk_irq(8'h0f, 5'h0f, 1'b1, 1'b0);
    end
  endtask

  task automatic t_merge();
    cpu_u.set_level(19, 5'h03);
    idle();
    ram = 6'h21;
    preq[19] = 1'b1;
    step();
    chk_irq(8'h23, 5'h03, 1'b0, 1'b0);
    chk_val(dma, 48'h0);
    for (int i = 0; i < 6; i++) begin
      idle();
      ram = 6'h01 << i;
      step();
      chk_val(pend, 48'h1 << 19);
    end
    idle();
    step();
    chk_val(pend, 48'h0);
    chk_flag(o_irq_valid, 1'b0);
    // Level 0 still masked: pending shows, nothing is presented
    preq[0] = 1'b1;
    step();
    chk_val(pend, 48'h1);
    chk_flag(o_irq_valid, 1'b0);
  endtask

  task automatic t_ext();
    cpu_u.set_level(1, 5'h07);
    idle();
    ext_hi = 8'h80;
    step();
    chk_irq(8'h11, 5'h07, 1'b0, 1'b0);
    chk_val(dma, 48'h2);
    idle();
    lvd = 1'b1;
    step();
    chk_val(pend, 48'h2);
    chk_val(dma, 48'h0);
  endtask

  task automatic t_sio();
    cpu_u.set_level(4, 5'h09);
    cpu_u.set_level(5, 5'h08);
    idle();
    sio = 7'h01;
    step();
    chk_irq(8'h14, 5'h09, 1'b0, 1'b0);
    chk_val(dma, 48'h0);
    preq[5] = 1'b1;
    step();
    chk_irq(8'h15, 5'h08, 1'b0, 1'b0);
    chk_val(dma, 48'h1 << 5);
  endtask

  task automatic t_frt();
    cpu_u.set_level(23, 5'h02);
    for (int i = 0; i < 2; i++) begin
      idle();
      {fc, fz} = 2'b01 << i;
      step();
      chk_irq(8'h27, 5'h02, 1'b0, 1'b0);
      chk_val(dma, 48'h1 << 23);
    end
  endtask

  task automatic t_cmp();
    cpu_u.set_level(42, 5'h04);
    cpu_u.set_level(43, 5'h04);
    for (int i = 0; i < 6; i++) begin
      idle();
      {cmp_b, cmp_a} = 6'h01 << i;
      step();
      chk_irq(i < 4 ? 8'h3a : 8'h3b, 5'h04, 1'b0, 1'b0);
      chk_val(dma, i < 4 ? 48'h1 << 42 : 48'h1 << 43);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    idle();
    exc = 7'h7f;
    repeat (6) step();
    chk_flag(o_irq_valid, 1'b0);
    chk_val(pend, 48'h0);
    i_rst = 1'b0;
    t_exc();
    t_nmi();
    t_merge();
    t_ext();
    t_sio();
    t_frt();
    t_cmp();
    chk_val(last_vec, 8'h3b);
    wrap_up();
  end

  // About 40 cycles of tests; fifteen times that is a hang
  initial begin
    #3000;
    n_fail++;
    wrap_up();
  end
endmodule
